// ---- dmrp_top.sv ----
// Purpose: mode register, command decode and ddr read/write data path of the memory
// Assumes: memory clock and pins are sampled by aclk, several aclk per memory clock
// Notes: memory contents are a small model array indexed by bank and burst beat
//
// Implementation choices: the register addresses and register access over AXI4-Lite.

// Behaviour
// - mode set captures address bits 0 to 17 into the mode register.
// - mode bits 0 to 2 pick one of five latency configurations.
// - write latency is always read latency plus one.
// - mode bits 3 and 4 give burst of 2, 4 or 8 words.
// - address bits in use shrink as burst length grows.
// - mode bit 5 switches read, write and mode set to two-part address.
// - multiplexed address comes in two parts on consecutive rising edges.
// - refresh needs no second part, so refreshes may follow every clock.
// - multiplexed mode costs bus efficiency only at burst length 2.
// - mode bit 7 enables the delay-locked loop, low keeps it off.
// - mode bit 8 picks reference resistor or internal impedance, both recalibrated.
// - mode bit 9 terminates write data, read data and mask pins.
// - read data termination off while driving, back on after last word.
// - read data after read latency, aligned to read clock; strobe half clock earlier.
// - strobe drops on last word; outputs float unless another read follows.
// - with chip select high a clock is a no-operation unless it takes the second part of a pending two-part address.
// - write words taken on both write clock edges, first at rising edge.
// - a write word whose mask is high is discarded.
module dmrp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [dmrp_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [dmrp_pkg::AXI_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [dmrp_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [dmrp_pkg::AXI_DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic mem_clock,
  input wire logic cs_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire logic [dmrp_pkg::ADDR_W-1:0] addr,
  input wire logic [dmrp_pkg::BANK_W-1:0] bank,
  input wire logic [dmrp_pkg::DATA_W-1:0] d,
  input wire logic write_word_mask,
  input wire logic write_data_clock,
  output logic [dmrp_pkg::DATA_W-1:0] q,
  output logic q_oe,
  output logic read_valid_strobe,
  output logic read_data_clock,
  output logic loop_enable,
  output logic impedance_source,
  output logic impedance_update,
  output logic d_term_en,
  output logic q_term_en
);
  typedef struct packed {
    logic ck_d;
    logic wck_d;
    logic [dmrp_pkg::MODE_W-1:0] mode;
    logic pend;
    dmrp_pkg::dmrp_cmd_e pend_cmd;
    logic [dmrp_pkg::MUX_W-1:0] pend_lo;
    logic [dmrp_pkg::BANK_W-1:0] pend_bank;
    logic [dmrp_pkg::PIPE_D-1:0] rd_v;
    logic [dmrp_pkg::PIPE_D-1:0][dmrp_pkg::MEM_AW-1:0] rd_a;
    logic [dmrp_pkg::PIPE_D-1:0] wr_v;
    logic [dmrp_pkg::PIPE_D-1:0][dmrp_pkg::MEM_AW-1:0] wr_a;
    logic [3:0] rd_left;
    logic [dmrp_pkg::MEM_AW-1:0] rd_idx;
    logic wr_on;
    logic [3:0] wr_left;
    logic [dmrp_pkg::MEM_AW-1:0] wr_idx;
    logic [dmrp_pkg::MEM_WORDS-1:0][dmrp_pkg::DATA_W-1:0] mem;
    logic [dmrp_pkg::DATA_W-1:0] q;
    logic q_oe;
    logic strobe;
    logic rclk;
    logic q_term;
    logic imp_upd;
    logic [10:0] lock_cnt;
    logic locked;
    logic [7:0] cal_cnt;
  } dmrp_top_s;

  function automatic logic [3:0] cfg_latency(input logic [2:0] cfg);
    case (cfg)
      dmrp_pkg::CFG_CODE_2: cfg_latency = dmrp_pkg::LAT_CFG_2;
      dmrp_pkg::CFG_CODE_3: cfg_latency = dmrp_pkg::LAT_CFG_3;
      dmrp_pkg::CFG_CODE_4: cfg_latency = dmrp_pkg::LAT_CFG_4;
      dmrp_pkg::CFG_CODE_5: cfg_latency = dmrp_pkg::LAT_CFG_5;
      default: cfg_latency = dmrp_pkg::LAT_CFG_1;
    endcase
  endfunction

  function automatic logic [3:0] burst_words(input logic [1:0] code);
    case (code)
      dmrp_pkg::BURST_CODE_4: burst_words = dmrp_pkg::BURST_WORDS_4;
      dmrp_pkg::BURST_CODE_8: burst_words = dmrp_pkg::BURST_WORDS_8;
      default: burst_words = dmrp_pkg::BURST_WORDS_2;
    endcase
  endfunction

  // first word of a burst: bank plus the beat position the used address bits give
  function automatic logic [dmrp_pkg::MEM_AW-1:0] start_index(
    input logic [1:0] code,
    input logic [dmrp_pkg::BANK_W-1:0] b,
    input logic [dmrp_pkg::ADDR_W-1:0] a
  );
    case (code)
      dmrp_pkg::BURST_CODE_8: start_index = {b, 3'h0};
      dmrp_pkg::BURST_CODE_4: start_index = {b, a[0], 2'h0};
      default: start_index = {b, a[1:0], 1'b0};
    endcase
  endfunction

  // beats wrap inside the bank row
  function automatic logic [dmrp_pkg::MEM_AW-1:0] next_index(
    input logic [dmrp_pkg::MEM_AW-1:0] i
  );
    next_index = {i[dmrp_pkg::MEM_AW-1:dmrp_pkg::BEAT_W], i[dmrp_pkg::BEAT_W-1:0] + 3'h1};
  endfunction

  dmrp_top_s r;
  dmrp_top_s next_r;
  logic [dmrp_pkg::SYNC_W-1:0] pins_s;
  logic ck_s;
  logic wck_s;
  logic cs_n_s;
  logic we_n_s;
  logic ref_n_s;
  logic [dmrp_pkg::ADDR_W-1:0] addr_s;
  logic [dmrp_pkg::BANK_W-1:0] bank_s;
  logic [dmrp_pkg::DATA_W-1:0] d_s;
  logic mask_s;
  logic ctrl_enable;
  logic [dmrp_pkg::STATUS_W-1:0] status_value;
  logic ck_rise;
  logic ck_fall;
  logic wck_rise;
  logic wck_fall;
  logic mux_mode;
  logic [1:0] burst_code;
  logic [3:0] burst;
  logic [3:0] read_latency_cycles;
  logic [3:0] write_latency_cycles;
  logic [3:0] rtap;
  dmrp_pkg::dmrp_cmd_e cmd;
  dmrp_pkg::dmrp_cmd_e exec;
  logic [dmrp_pkg::ADDR_W-1:0] full_a;
  logic [dmrp_pkg::BANK_W-1:0] full_bank;
  logic [dmrp_pkg::MEM_AW-1:0] sidx;
  logic rd_start;
  logic arm;
  logic w_on;
  logic [3:0] w_left;
  logic [dmrp_pkg::MEM_AW-1:0] w_idx;

  dmrp_sync #(
    .W(dmrp_pkg::SYNC_W)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .din({mem_clock, write_data_clock, cs_n, we_n, ref_n, addr, bank, d, write_word_mask}),
    .dout(pins_s)
  );

  assign {ck_s, wck_s, cs_n_s, we_n_s, ref_n_s, addr_s, bank_s, d_s, mask_s} = pins_s;

  dmrp_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .mode_value(r.mode),
    .status_value(status_value),
    .ctrl_enable(ctrl_enable)
  );

  assign mux_mode = r.mode[dmrp_pkg::MUX_BIT];
  assign burst_code = r.mode[dmrp_pkg::BURST_MSB:dmrp_pkg::BURST_LSB];
  assign burst = burst_words(burst_code);
  assign read_latency_cycles = cfg_latency(r.mode[dmrp_pkg::CFG_MSB:dmrp_pkg::CFG_LSB]);
  assign write_latency_cycles = read_latency_cycles + dmrp_pkg::WRITE_EXTRA;
  assign rtap = read_latency_cycles - 4'h1;
  assign status_value = {r.locked, r.pend, r.q_oe, r.wr_on, write_latency_cycles,
                         read_latency_cycles};

  always_comb begin
    next_r = r;
    ck_rise = ck_s & ~r.ck_d;
    ck_fall = ~ck_s & r.ck_d;
    wck_rise = wck_s & ~r.wck_d;
    wck_fall = ~wck_s & r.wck_d;
    next_r.ck_d = ck_s;
    next_r.wck_d = wck_s;
    next_r.rclk = ck_s;
    next_r.imp_upd = 1'b0;
    cmd = dmrp_pkg::CMD_NOP;
    exec = dmrp_pkg::CMD_NOP;
    full_a = addr_s;
    full_bank = bank_s;
    // software can hold the device deaf by clearing the enable bit
    if (!cs_n_s && ctrl_enable) begin
      case ({we_n_s, ref_n_s})
        2'b00: cmd = dmrp_pkg::CMD_MODE_SET;
        2'b11: cmd = dmrp_pkg::CMD_READ;
        2'b01: cmd = dmrp_pkg::CMD_WRITE;
        default: cmd = dmrp_pkg::CMD_REFRESH;
      endcase
    end
    if (ck_rise) begin
      if (r.pend) begin
        // second edge of a two-part address: upper bits on the low lines
        exec = r.pend_cmd;
        full_a = {addr_s[dmrp_pkg::ADDR_W-dmrp_pkg::MUX_W-1:0], r.pend_lo};
        full_bank = r.pend_bank;
        next_r.pend = 1'b0;
      end else if (mux_mode && cmd != dmrp_pkg::CMD_NOP && cmd != dmrp_pkg::CMD_REFRESH) begin
        next_r.pend = 1'b1;
        next_r.pend_cmd = cmd;
        next_r.pend_lo = addr_s[dmrp_pkg::MUX_W-1:0];
        next_r.pend_bank = bank_s;
      end else begin
        exec = cmd;
      end
      if (exec == dmrp_pkg::CMD_MODE_SET) begin
        next_r.mode = full_a[dmrp_pkg::MODE_W-1:0];
      end
    end
    sidx = start_index(burst_code, full_bank, full_a);
    if (ck_rise) begin
      next_r.rd_v = {r.rd_v[dmrp_pkg::PIPE_D-2:0], exec == dmrp_pkg::CMD_READ};
      next_r.rd_a = {r.rd_a[dmrp_pkg::PIPE_D-2:0], sidx};
      next_r.wr_v = {r.wr_v[dmrp_pkg::PIPE_D-2:0], exec == dmrp_pkg::CMD_WRITE};
      next_r.wr_a = {r.wr_a[dmrp_pkg::PIPE_D-2:0], sidx};
      next_r.cal_cnt = r.cal_cnt + 8'h01;
      // both impedance sources are retuned on the same period
      if (r.cal_cnt == dmrp_pkg::IMP_CNT_LAST) begin
        next_r.imp_upd = 1'b1;
      end
    end

    // read path: one word on each memory clock edge
    rd_start = ck_rise && r.rd_v[rtap];
    if (ck_rise || ck_fall) begin
      if (rd_start) begin
        next_r.q = r.mem[r.rd_a[rtap]];
        next_r.rd_idx = next_index(r.rd_a[rtap]);
        next_r.rd_left = burst - 4'h1;
        next_r.q_oe = 1'b1;
        next_r.q_term = 1'b0;
      end else if (r.rd_left != 4'h0) begin
        next_r.q = r.mem[r.rd_idx];
        next_r.rd_idx = next_index(r.rd_idx);
        next_r.rd_left = r.rd_left - 4'h1;
        if (r.rd_left == 4'h1) begin
          next_r.strobe = 1'b0;
        end
      end else begin
        next_r.q = '0;
        next_r.q_oe = 1'b0;
      end
      // raising wins over dropping so back-to-back bursts keep the strobe high
      if (ck_fall && r.rd_v[rtap]) begin
        next_r.strobe = 1'b1;
      end
    end
    if (!next_r.q_oe) begin
      next_r.q_term = r.mode[dmrp_pkg::TERM_BIT];
    end

    // write path: armed at write latency, first word on a rising write clock
    arm = ck_rise && r.wr_v[read_latency_cycles];
    w_on = arm | r.wr_on;
    w_idx = arm ? r.wr_a[read_latency_cycles] : r.wr_idx;
    w_left = arm ? burst : r.wr_left;
    next_r.wr_on = w_on;
    next_r.wr_idx = w_idx;
    next_r.wr_left = w_left;
    if (w_on && (wck_rise || (wck_fall && w_left != burst))) begin
      if (!mask_s) begin
        next_r.mem[w_idx] = d_s;
      end
      next_r.wr_idx = next_index(w_idx);
      next_r.wr_left = w_left - 4'h1;
      if (w_left == 4'h1) begin
        next_r.wr_on = 1'b0;
      end
    end

    // loop lock counter restarts whenever the loop is switched off
    if (!r.mode[dmrp_pkg::LOOP_BIT]) begin
      next_r.lock_cnt = '0;
      next_r.locked = 1'b0;
    end else if (ck_rise && !r.locked) begin
      next_r.lock_cnt = r.lock_cnt + 11'h001;
      if (r.lock_cnt == dmrp_pkg::LOCK_LAST) begin
        next_r.locked = 1'b1;
      end
    end
  end

  localparam dmrp_top_s TOP_RESET = '{mode: dmrp_pkg::MODE_RESET, pend_cmd: dmrp_pkg::CMD_NOP,
                                      default: '0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= TOP_RESET;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign q = r.q;
  assign q_oe = r.q_oe;
  assign read_valid_strobe = r.strobe;
  assign read_data_clock = r.rclk;
  assign loop_enable = r.mode[dmrp_pkg::LOOP_BIT];
  assign impedance_source = r.mode[dmrp_pkg::IMP_BIT];
  assign impedance_update = r.imp_upd;
  assign d_term_en = r.mode[dmrp_pkg::TERM_BIT];
  assign q_term_en = r.q_term;
endmodule

// ---- dmrp_pkg.sv ----
// Purpose: shared constants and types for the dram mode register and read path
// Assumes: one 250 MHz fabric clock samples every pin, memory clock included
// Notes: mode field encodings are fixed here and may be changed in one place
package dmrp_pkg;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 18;
  localparam int BANK_W = 3;
  localparam int MODE_W = 18;
  localparam int MUX_W = 11;
  localparam int BEAT_W = 3;
  localparam int MEM_AW = BANK_W + BEAT_W;
  localparam int MEM_WORDS = 1 << MEM_AW;
  localparam int PIPE_D = 9;
  localparam int SYNC_W = 5 + ADDR_W + BANK_W + DATA_W + 1;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int STATUS_W = 12;

  // mode register fields
  localparam int CFG_LSB = 0;
  localparam int CFG_MSB = 2;
  localparam int BURST_LSB = 3;
  localparam int BURST_MSB = 4;
  localparam int MUX_BIT = 5;
  localparam int LOOP_BIT = 7;
  localparam int IMP_BIT = 8;
  localparam int TERM_BIT = 9;
  localparam logic [MODE_W-1:0] MODE_RESET = 18'h00000;

  // configuration codes and their read latency (row cycle equals it)
  localparam logic [2:0] CFG_CODE_1 = 3'h1;
  localparam logic [2:0] CFG_CODE_2 = 3'h2;
  localparam logic [2:0] CFG_CODE_3 = 3'h3;
  localparam logic [2:0] CFG_CODE_4 = 3'h4;
  localparam logic [2:0] CFG_CODE_5 = 3'h5;
  localparam logic [3:0] LAT_CFG_1 = 4'h4;
  localparam logic [3:0] LAT_CFG_2 = 4'h6;
  localparam logic [3:0] LAT_CFG_3 = 4'h8;
  localparam logic [3:0] LAT_CFG_4 = 4'h3;
  localparam logic [3:0] LAT_CFG_5 = 4'h5;
  localparam logic [3:0] WRITE_EXTRA = 4'h1;

  // burst length codes
  localparam logic [1:0] BURST_CODE_2 = 2'h0;
  localparam logic [1:0] BURST_CODE_4 = 2'h1;
  localparam logic [1:0] BURST_CODE_8 = 2'h2;
  localparam logic [3:0] BURST_WORDS_2 = 4'h2;
  localparam logic [3:0] BURST_WORDS_4 = 4'h4;
  localparam logic [3:0] BURST_WORDS_8 = 4'h8;

  // timing in memory clocks
  localparam logic [10:0] LOCK_LAST = 11'h3ff;
  localparam logic [7:0] IMP_CNT_LAST = 8'hff;

  // register map
  localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] REG_MODE = 8'h04;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h08;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_MODE_SET,
    CMD_READ,
    CMD_WRITE,
    CMD_REFRESH
  } dmrp_cmd_e;
endpackage

// ---- dmrp_sync.sv ----
// Purpose: two-stage synchroniser for pins sampled by the fabric clock
// Assumes: each bit is treated as an independent level
// Notes: only the second stage is visible outside
module dmrp_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } dmrp_sync_s;

  dmrp_sync_s r;
  dmrp_sync_s next_r;

  always_comb begin
    next_r = r;
    next_r.meta = din;
    next_r.stab = r.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign dout = r.stab;
endmodule

// ---- dmrp_axil.sv ----
// Purpose: axi4-lite slave holding control and showing mode and status
// Assumes: one write and one read under way at a time
// Notes: read-only offsets accept writes with okay and keep their value
module dmrp_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [dmrp_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [dmrp_pkg::AXI_DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [dmrp_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [dmrp_pkg::AXI_DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [dmrp_pkg::MODE_W-1:0] mode_value,
  input wire logic [dmrp_pkg::STATUS_W-1:0] status_value,
  output logic ctrl_enable
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [dmrp_pkg::AXI_AW-1:0] waddr;
    logic [dmrp_pkg::AXI_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [dmrp_pkg::AXI_DW-1:0] rdata;
    logic [1:0] rresp;
    logic enable;
  } dmrp_axil_s;

  localparam dmrp_axil_s AXIL_RESET = '{enable: dmrp_pkg::CTRL_ENABLE_RESET, default: '0};

  dmrp_axil_s r;
  dmrp_axil_s next_r;

  always_comb begin
    next_r = r;
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    if (awvalid && r.awready) begin
      next_r.aw_got = 1'b1;
      next_r.waddr = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.w_got = 1'b1;
      next_r.wdata = wdata;
      next_r.wstrb = wstrb;
    end
    if (next_r.aw_got && next_r.w_got && !next_r.bvalid) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = dmrp_pkg::RESP_OKAY;
      if (next_r.waddr == dmrp_pkg::REG_CTRL) begin
        if (next_r.wstrb[0]) begin
          next_r.enable = next_r.wdata[dmrp_pkg::CTRL_ENABLE_BIT];
        end
      end else if (next_r.waddr == dmrp_pkg::REG_MODE) begin
        next_r.bresp = dmrp_pkg::RESP_OKAY;
      end else if (next_r.waddr == dmrp_pkg::REG_STATUS) begin
        next_r.bresp = dmrp_pkg::RESP_OKAY;
      end else begin
        next_r.bresp = dmrp_pkg::RESP_SLVERR;
      end
    end
    if (arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = dmrp_pkg::RESP_OKAY;
      if (araddr == dmrp_pkg::REG_CTRL) begin
        next_r.rdata = dmrp_pkg::AXI_DW'(r.enable);
      end else if (araddr == dmrp_pkg::REG_MODE) begin
        next_r.rdata = dmrp_pkg::AXI_DW'(mode_value);
      end else if (araddr == dmrp_pkg::REG_STATUS) begin
        next_r.rdata = dmrp_pkg::AXI_DW'(status_value);
      end else begin
        next_r.rdata = '0;
        next_r.rresp = dmrp_pkg::RESP_SLVERR;
      end
    end
    // ready is registered, so it is worked out from the state just computed
    next_r.awready = !next_r.aw_got && !next_r.bvalid;
    next_r.wready = !next_r.w_got && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= AXIL_RESET;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign awready = r.awready;
  assign wready = r.wready;
  assign bresp = r.bresp;
  assign bvalid = r.bvalid;
  assign arready = r.arready;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign rvalid = r.rvalid;
  assign ctrl_enable = r.enable;
endmodule

// ---- dmrp_chk.sv ----
// Purpose: concurrent checks on the read path and mode outputs
// Assumes: single aclk domain, ce held high
// Notes: bound to every dmrp_top instance
module dmrp_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_clock,
  input wire logic cs_n,
  input wire logic [dmrp_pkg::DATA_W-1:0] q,
  input wire logic q_oe,
  input wire logic read_valid_strobe,
  input wire logic read_data_clock,
  input wire logic loop_enable,
  input wire logic impedance_source,
  input wire logic impedance_update,
  input wire logic d_term_en,
  input wire logic q_term_en
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a whole memory clock deselected also covers a pending second address part
  logic [5:0] hi_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !cs_n) hi_cnt <= 6'h00;
    else if (hi_cnt != 6'h3f) hi_cnt <= hi_cnt + 6'h01;
  end
  sequence s_data_start;
    ##[16:24] q_oe;
  endsequence
  property p_q_idle;
    !q_oe |-> q == '0;
  endproperty
  property p_drive_unterm;
    q_oe |-> !q_term_en;
  endproperty
  property p_term_back;
    $fell(q_oe) |-> q_term_en == d_term_en;
  endproperty
  property p_strobe_first;
    $rose(q_oe) |-> $past(read_valid_strobe);
  endproperty
  property p_strobe_lead;
    $rose(read_valid_strobe) && !q_oe |-> s_data_start;
  endproperty
  property p_rclk_runs;
    $rose(mem_clock) |-> ##[1:6] read_data_clock;
  endproperty
  property p_strobe_last;
    $fell(read_valid_strobe) |-> q_oe;
  endproperty
  property p_imp_pulse;
    impedance_update |=> !impedance_update;
  endproperty
  property p_desel_nop;
    hi_cnt >= 6'd50 |=> $stable({loop_enable, impedance_source, d_term_en});
  endproperty
  a_q_idle: assert property (p_q_idle) else $error("read data not zero while undriven");
  a_drive_unterm: assert property (p_drive_unterm) else $error("termination on while driving");
  a_term_back: assert property (p_term_back) else $error("termination not restored");
  a_strobe_first: assert property (p_strobe_first) else $error("data before strobe");
  a_strobe_lead: assert property (p_strobe_lead) else $error("strobe without data");
  a_rclk_runs: assert property (p_rclk_runs) else $error("read clock not following");
  a_strobe_last: assert property (p_strobe_last) else $error("strobe fell off burst");
  a_imp_pulse: assert property (p_imp_pulse) else $error("impedance update too long");
  a_desel_nop: assert property (p_desel_nop) else $error("mode changed while deselected");
endmodule
bind dmrp_top dmrp_chk dmrp_chk_i (
  .aclk, .aresetn, .mem_clock, .cs_n, .q, .q_oe, .read_valid_strobe, .read_data_clock,
  .loop_enable, .impedance_source, .impedance_update, .d_term_en, .q_term_en
);

// ---- dmrp_ctl_model.sv ----
// Purpose: memory controller model driving command, address and write data pins
// Assumes: memory clock is 40 aclk, pins change mid-phase
// Notes: write data is a fixed half-cycle pattern, so expectations need no capture
module dmrp_ctl_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mask_on,
  output logic mem_clock,
  output logic cs_n,
  output logic we_n,
  output logic ref_n,
  output logic [19:0] addr,
  output logic [2:0] bank,
  output logic [17:0] d,
  output logic write_word_mask,
  output logic write_data_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] ph = 6'd20;
  int rises = 0;
  function automatic logic [17:0] word_at(input int h);
    return 18'h2a5a5 ^ 18'(h * 1093);
  endfunction
  initial begin
    {mem_clock, write_data_clock, write_word_mask, cs_n, we_n, ref_n} = 6'h0f;
    addr = '0;
    bank = '0;
    d = '0;
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      ph <= 6'd20;
      rises <= 0;
    end else begin
      ph <= (ph == 6'd39) ? 6'd0 : ph + 6'd1;
      mem_clock <= (ph == 6'd39) || (ph < 6'd19);
      write_data_clock <= (ph == 6'd39) || (ph < 6'd19);
      if (ph == 6'd39) rises <= rises + 1;
      if (ph == 6'd29) d <= word_at(2 * rises + 2);
      if (ph == 6'd9) d <= word_at(2 * rises + 1);
      if (ph == 6'd9) write_word_mask <= mask_on;
      if (ph == 6'd29) write_word_mask <= 1'b0;
    end
  end
  // pins hold across the rise, then chip select goes high and the rest show the inverse so stale values never match
  task automatic cmd(input logic sel_n, input logic [1:0] c, input logic [19:0] a,
                     input logic [2:0] b, output int r);
    @(posedge aclk iff ph == 6'd29);
    cs_n <= sel_n;
    {we_n, ref_n} <= c;
    addr <= a;
    bank <= b;
    r = rises + 1;
    @(posedge aclk iff ph == 6'd9);
    cs_n <= 1'b1;
    {we_n, ref_n} <= ~c;
    addr <= ~a;
    bank <= ~b;
  endtask
endmodule

// ---- dmrp_top_tb.sv ----
// Purpose: self-checking bench for the mode register and read path
// Assumes: memory clock is forty aclk periods
// Notes: axi tasks wait on handshakes; the watchdog bounds every wait
module dmrp_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic mask_on = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, q_oe, read_valid_strobe, read_data_clock;
  logic loop_enable, impedance_source, impedance_update, d_term_en, q_term_en;
  logic mem_clock, cs_n, we_n, ref_n, write_word_mask, write_data_clock;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  logic [19:0] addr;
  logic [2:0] bank;
  logic [17:0] d, q, m, w0, w1;
  logic [3:0] lat_of [5] = '{4'h4, 4'h6, 4'h8, 4'h3, 4'h5};
  int n_mismatch = 0, n_checks = 0, rw, rr, k;
  always #2 aclk = ~aclk;
  dmrp_top dmrp_top_i (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .mem_clock, .cs_n, .we_n, .ref_n, .addr, .bank, .d,
    .write_word_mask, .write_data_clock, .q, .q_oe, .read_valid_strobe, .read_data_clock,
    .loop_enable, .impedance_source, .impedance_update, .d_term_en, .q_term_en);
  dmrp_ctl_model ctl_i (.aclk, .aresetn, .mask_on, .mem_clock, .cs_n, .we_n, .ref_n,
    .addr, .bank, .d, .write_word_mask, .write_data_clock);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] e);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, x, 3'b111};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    e = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] e);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    {x, e} = {rdata, rresp};
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic at(input int n, input logic [5:0] p);
    @(posedge aclk iff (ctl_i.rises == n && ctl_i.ph == p));
  endtask
  // mode values keep address bits 10 to 17 low, banks idle
  task automatic ms(input logic [17:0] x);
    int t;
    ctl_i.cmd(1'b0, 2'b00, {2'b00, x}, 3'h0, t);
    repeat (80) @(posedge aclk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(dmrp_pkg::REG_MODE, v, r);
    chk(v, 32'h0);
    rd(8'h0c, v, r);
    chk(32'(r), 32'(dmrp_pkg::RESP_SLVERR));
    wr(8'h0c, 32'h0, r);
    chk(32'(r), 32'(dmrp_pkg::RESP_SLVERR));
    for (k = 0; k < 5; k++) begin
      m = {8'h00, k[0], k[1], ~k[0], 2'b00, 2'(k % 4), 3'(k + 1)};
      ms(m);
      rd(dmrp_pkg::REG_MODE, v, r);
      chk(v, 32'(m));
      rd(dmrp_pkg::REG_STATUS, v, r);
      chk(v & 32'hff, {24'h0, lat_of[k] + 4'h1, lat_of[k]});
      chk(32'({d_term_en, impedance_source, loop_enable}), 32'(m[9:7]));
    end
    ctl_i.cmd(1'b1, 2'b00, 20'h0, 3'h0, rw);
    wr(dmrp_pkg::REG_CTRL, 32'h0, r);
    ms(18'h0);
    wr(dmrp_pkg::REG_CTRL, 32'h1, r);
    rd(dmrp_pkg::REG_MODE, v, r);
    chk(v, 32'(m));
    ms(18'h00020);
    for (k = 1; k < 4; k++) ctl_i.cmd(1'b0, 2'b10, 20'h0, 3'(k), rw);
    at(rw + 4, 6'd0);
    ctl_i.cmd(1'b0, 2'b00, 20'h00204, 3'h0, rw);
    ms(18'h0);
    ctl_i.cmd(1'b0, 2'b01, 20'h0, 3'h5, rw);
    w1 = ctl_i.word_at(2 * rw + 9);
    at(rw + 6, 6'd0);
    mask_on <= 1'b1;
    ctl_i.cmd(1'b0, 2'b01, 20'h0, 3'h5, rw);
    w0 = ctl_i.word_at(2 * rw + 8);
    at(rw + 6, 6'd0);
    mask_on <= 1'b0;
    ctl_i.cmd(1'b0, 2'b11, 20'h0, 3'h5, rr);
    ctl_i.cmd(1'b0, 2'b11, 20'h0, 3'h6, rw);
    at(rr + 2, 6'd10);
    chk(32'({q_oe, read_valid_strobe}), 32'h0);
    at(rr + 2, 6'd30);
    chk(32'({q_oe, read_valid_strobe}), 32'h1);
    at(rr + 3, 6'd10);
    chk(32'({q_oe, q_term_en, read_valid_strobe}), 32'h5);
    chk(32'(q), 32'(w0));
    at(rr + 3, 6'd30);
    chk(32'(q), 32'(w1));
    at(rr + 4, 6'd10);
    chk(32'({q_oe, q_term_en}), 32'h2);
    at(rr + 4, 6'd30);
    chk(32'({q_oe, read_valid_strobe}), 32'h2);
    at(rr + 5, 6'd10);
    chk({13'h0, q_oe, q_term_en, q}, 32'h40000);
    @(posedge aclk iff impedance_update);
    chk(32'(ctl_i.rises), 32'h100);
    close_out();
  end
endmodule
